// ===== design/obc_map.svh
// register offsets, field positions, reset values and timing counts for the option command set
`ifndef OBC_MAP_SVH
`define OBC_MAP_SVH

// register byte offsets
`define OBC_CMD_OFS       8'h00
`define OBC_STAT_OFS      8'h04
`define OBC_PROTO_OFS     8'h08
`define OBC_FCID_OFS      8'h0C
`define OBC_FCDATA_LO_OFS 8'h10
`define OBC_FCDATA_HI_OFS 8'h14
`define OBC_EVENT_OFS     8'h18
`define OBC_DESC_OFS      8'h1C
`define OBC_IDENT_OFS     8'h20

// command register fields
`define OBC_CMD_CODE_LSB  0
`define OBC_CMD_ARG_LSB   8
`define OBC_CMD_LEN_LSB   16

// event register bits (search block parameter bits)
`define OBC_BLK_FATAL_BIT 5
`define OBC_BLK_LV_BIT    4

// reset values
`define OBC_ECHO_RST      1'b1
`define OBC_HDR_RST       1'b0
`define OBC_PROTO_RST     4'h0
`define OBC_AUTO_RST      1'b1
`define OBC_FILLER_RST    8'h00

// protocol numbers
`define OBC_PROTO_KWP_FAST 4'h5
`define OBC_PROTO_ISO_LO   4'h3
`define OBC_PROTO_ISO_HI   4'h5
`define OBC_PROTO_CAN_LO   4'h6
`define OBC_PROTO_CAN_HI   4'hC

// identifier masks
`define OBC_ID11_MASK     32'h0000_07FF
`define OBC_ID29_MASK     32'h1FFF_FFFF

// iso baud rates
`define OBC_BAUD_10400    16'd10400
`define OBC_BAUD_4800     16'd4800
`define OBC_BAUD_9600     16'd9600

// arbitrary identification word, not tied to any real part
`define OBC_IDENT_WORD    32'h0B1D_0001

// timing: fast init pulse length in ns and derived cycles at 100 MHz
`define OBC_CLK_NS        10
`define OBC_FI_LOW_NS     25000
`define OBC_FI_CYC        (`OBC_FI_LOW_NS / `OBC_CLK_NS)

`endif

// ===== design/obc_pkg.sv
// types shared by the option command set block
package obc_pkg;

	typedef enum logic [3:0] {
		OBC_OP_NOP,
		OBC_OP_ECHO_OFF,
		OBC_OP_ECHO_ON,
		OBC_OP_HDR_OFF,
		OBC_OP_HDR_ON,
		OBC_OP_FC_DATA,
		OBC_OP_FC_ID11,
		OBC_OP_FC_ID29,
		OBC_OP_FC_MODE,
		OBC_OP_FORGET,
		OBC_OP_FAST_INIT,
		OBC_OP_ISO_RATE,
		OBC_OP_IFR,
		OBC_OP_SET_PROTO,
		OBC_OP_DEFAULTS
	} obc_op_t;

	typedef enum logic [1:0] {
		OBC_IFR_NEVER  = 2'h0,
		OBC_IFR_HEADER = 2'h1,
		OBC_IFR_ALWAYS = 2'h2
	} obc_ifr_t;

	typedef enum logic [1:0] {
		OBC_FC_AUTO = 2'h0,
		OBC_FC_USER = 2'h1,
		OBC_FC_DATA = 2'h2
	} obc_fcm_t;

	typedef enum logic [1:0] {
		OBC_ISO_10400 = 2'h0,
		OBC_ISO_4800  = 2'h1,
		OBC_ISO_9600  = 2'h2
	} obc_iso_t;

	typedef enum {
		OBC_ST_IDLE,
		OBC_ST_FI
	} obc_st_t;

endpackage

// ===== design/obc_core.sv
// option command interpreter: echo, headers, flow control, events, iso rate, ifr, fast init
// What this block does
// - describe query prefixes AUTO, reports protocol
// - number query prefixes A when auto on
// - echo received characters while echo enabled
// - flow data one to five, pad filler
// - user flow data used only modes 1,2
// - 11-bit flow id keeps low 11 bits
// - 29-bit flow id keeps low 29 bits
// - flow mode 0 auto, 1 user, 2 data
// - reject mode 1/2 without needed data
// - fatal CAN error blocks CAN search if bit5
// - low voltage reset blocks if bit4
// - fast init only under protocol 5
// - protocol change closes active protocol
// - headers on show full message, no CRC/IFR
// - headers off by default, data only
// - identify returns startup id string
// - iso rate default 10400, restorable
// - 4800 setting, relaxed init timing
// - 9600 setting, relaxed init timing
// - J1850 IFR follows K bit by default
// - IFR never, by K bit, always
// - auto flow control answers first frames
`timescale 1ns/100ps
`default_nettype none
`include "obc_map.svh"

module obc_core
	import obc_pkg::*;
#(
	parameter int FI_CYC = `OBC_FI_CYC
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [7:0]  HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// serial receive character and echo
	input  wire logic [7:0]  RX_CHAR,
	input  wire logic        RX_VALID,
	output logic [7:0]       ECHO_CHAR,
	output logic             ECHO_VALID,
	// vehicle side events and messages
	input  wire logic        FATAL_CAN_ERROR_EVENT,
	input  wire logic        LOW_VOLTAGE_RESET_EVENT,
	input  wire logic        FIRST_FRAME_RX,
	input  wire logic        J1850_MSG_RX,
	input  wire logic        J1850_K_BIT,
	// vehicle side controls
	output logic             FLOW_CTRL_SEND,
	output logic             IFR_SEND,
	output logic             PROTO_CLOSE,
	output logic             FAST_INIT_ACTIVE,
	output logic             CAN_SEARCH_BLOCKED,
	output logic             SHOW_HEADERS,
	output logic [15:0]      ISO_BAUD,
	output logic             ISO_RELAXED_INIT
);

	//--------------------------------------------------------------
	// register map, one word each
	//--------------------------------------------------------------
	// 0x00 command: op in [3:0], argument in [15:8], length in [18:16]
	// 0x04 status: echo, headers, length, flow mode, rate, ifr, error, busy
	// 0x08 protocol number with the automatic search flag in bit 4
	// 0x0C flow control identifier, trimmed by the id commands
	// 0x10 flow control data bytes 0 to 3
	// 0x14 data byte 4, filler byte, automatic flow control enable
	// 0x18 search block parameter, latched events in bits 8 and 9
	// 0x1C protocol description: number, automatic flag in bit 16
	// 0x20 identification word
	// read data stands in the cycle after the address phase; no wait states

	//--------------------------------------------------------------
	// state
	//--------------------------------------------------------------
	typedef struct packed {
		logic        echo;
		logic        hdr;
		logic        auto_srch;
		logic [3:0]  proto;
		logic [31:0] fc_id;
		logic        fc_id_ok;
		logic [39:0] fc_data;
		logic [2:0]  fc_len;
		obc_fcm_t    fc_mode;
		logic        auto_fc;
		logic [7:0]  filler;
		logic [7:0]  blk_param;
		logic        ev_fatal;
		logic        ev_lv;
		obc_iso_t    iso;
		obc_ifr_t    ifr;
		logic        err;
		obc_st_t     st;
		logic [31:0] fi_cnt;
		logic        ph_wr;
		logic        ph_rd;
		logic [7:0]  ph_addr;
		logic [31:0] rdata;
		logic [7:0]  echo_c;
		logic        echo_v;
		logic        fc_send;
		logic        ifr_send;
		logic        close;
		logic        fi_act;
		logic        relaxed;
		logic        blk;
		logic [15:0] baud;
		logic        rdy;
	} obc_state_t;

	obc_state_t s_q, s_d;

	logic        acc;
	obc_op_t     op;
	logic [7:0]  arg;
	logic [2:0]  len;
	logic        user_data;
	wire logic [39:0] fc_pad;

	assign acc = HSEL & HREADY & HTRANS[1];
	assign op  = obc_op_t'(HWDATA[`OBC_CMD_CODE_LSB +: 4]);
	assign arg = HWDATA[`OBC_CMD_ARG_LSB +: 8];
	assign len = HWDATA[`OBC_CMD_LEN_LSB +: 3];

	//--------------------------------------------------------------
	// flow control frame padding
	//--------------------------------------------------------------
	// bytes past the defined count read back as the filler byte they go out as;
	// byte 0 is the first data byte of the frame and sits in the low bits
	for (genvar b = 0; b < 5; b++) begin : g_pad
		assign fc_pad[8*b +: 8] = (3'(b) < s_q.fc_len) ? s_q.fc_data[8*b +: 8]
			: s_q.filler;
	end

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.echo_v   = 1'b0;
		s_d.fc_send  = 1'b0;
		s_d.ifr_send = 1'b0;
		s_d.close    = 1'b0;
		user_data    = 1'b0;
		// echo every received character while enabled
		if (RX_VALID && s_q.echo) begin
			s_d.echo_c = RX_CHAR;
			s_d.echo_v = 1'b1;
		end
		// latched search blocking events; set wins over forget
		if (FATAL_CAN_ERROR_EVENT)
			s_d.ev_fatal = 1'b1;
		if (LOW_VOLTAGE_RESET_EVENT)
			s_d.ev_lv = 1'b1;
		// first frame reply under automatic flow control
		if (FIRST_FRAME_RX && s_q.auto_fc)
			s_d.fc_send = 1'b1;
		// in-frame response after each J1850 message
		if (J1850_MSG_RX) begin
			case (s_q.ifr)
				OBC_IFR_NEVER:  s_d.ifr_send = 1'b0;
				OBC_IFR_ALWAYS: s_d.ifr_send = 1'b1;
				default:        s_d.ifr_send = J1850_K_BIT;
			endcase
		end
		// fast init sequence timer
		case (s_q.st)
			OBC_ST_FI: begin
				if (s_q.fi_cnt >= 32'(FI_CYC - 1))
					s_d.st = OBC_ST_IDLE;
				else
					s_d.fi_cnt = s_q.fi_cnt + 32'h0000_0001;
			end
			default: ;
		endcase
		// bus data phase for writes
		if (s_q.ph_wr) begin
			case (s_q.ph_addr)
				`OBC_CMD_OFS: begin
					s_d.err = 1'b0;
					case (op)
						// echo and header display switches
						OBC_OP_ECHO_OFF: s_d.echo = 1'b0;
						OBC_OP_ECHO_ON:  s_d.echo = 1'b1;
						OBC_OP_HDR_OFF:  s_d.hdr = 1'b0;
						OBC_OP_HDR_ON:   s_d.hdr = 1'b1;
						// a length outside one to five is refused, old length kept
						OBC_OP_FC_DATA: begin
							if (len >= 3'h1 && len <= 3'h5) begin
								s_d.fc_len = len;
							end else begin
								s_d.err = 1'b1;
							end
						end
						// id commands trim the stored identifier to the id width
						OBC_OP_FC_ID11: begin
							s_d.fc_id    = s_q.fc_id & `OBC_ID11_MASK;
							s_d.fc_id_ok = 1'b1;
						end
						OBC_OP_FC_ID29: begin
							s_d.fc_id    = s_q.fc_id & `OBC_ID29_MASK;
							s_d.fc_id_ok = 1'b1;
						end
						// user modes need their data, and mode 1 an identifier too
						OBC_OP_FC_MODE: begin
							case (arg)
								8'h00: s_d.fc_mode = OBC_FC_AUTO;
								8'h01: begin
									if (s_q.fc_len != 3'h0 && s_q.fc_id_ok)
										s_d.fc_mode = OBC_FC_USER;
									else
										s_d.err = 1'b1;
								end
								8'h02: begin
									if (s_q.fc_len != 3'h0)
										s_d.fc_mode = OBC_FC_DATA;
									else
										s_d.err = 1'b1;
								end
								default: s_d.err = 1'b1;
							endcase
						end
						// an event arriving with the forget command stays latched
						OBC_OP_FORGET: begin
							s_d.ev_fatal = FATAL_CAN_ERROR_EVENT;
							s_d.ev_lv    = LOW_VOLTAGE_RESET_EVENT;
						end
						// fast init runs only under the fast keyword protocol
						OBC_OP_FAST_INIT: begin
							if (s_q.proto == `OBC_PROTO_KWP_FAST) begin
								s_d.st     = OBC_ST_FI;
								s_d.fi_cnt = 32'h0000_0000;
							end else begin
								s_d.err = 1'b1;
							end
						end
						// unknown rate codes are refused and the rate is kept
						OBC_OP_ISO_RATE: begin
							case (arg)
								8'h10: s_d.iso = OBC_ISO_10400;
								8'h48: s_d.iso = OBC_ISO_4800;
								8'h96: s_d.iso = OBC_ISO_9600;
								default: s_d.err = 1'b1;
							endcase
						end
						// ifr settings above two are refused
						OBC_OP_IFR: begin
							if (arg <= 8'h02)
								s_d.ifr = obc_ifr_t'(arg[1:0]);
							else
								s_d.err = 1'b1;
						end
						// a new protocol number closes the one that was active
						OBC_OP_SET_PROTO: begin
							s_d.auto_srch = arg[4];
							s_d.proto     = arg[3:0];
							if (arg[3:0] != s_q.proto)
								s_d.close = 1'b1;
						end
						// defaults return echo, headers, flow mode, iso rate, ifr and automatic flow control to their power-up values
						OBC_OP_DEFAULTS: begin
							s_d.echo    = `OBC_ECHO_RST;
							s_d.hdr     = `OBC_HDR_RST;
							s_d.fc_mode = OBC_FC_AUTO;
							s_d.iso     = OBC_ISO_10400;
							s_d.ifr     = OBC_IFR_HEADER;
							s_d.auto_fc = 1'b1;
						end
						default: ;
					endcase
				end
				// plain data words
				`OBC_FCID_OFS:      s_d.fc_id = HWDATA;
				`OBC_FCDATA_LO_OFS: s_d.fc_data[31:0] = HWDATA;
				`OBC_FCDATA_HI_OFS: begin
					s_d.fc_data[39:32] = HWDATA[7:0];
					s_d.filler         = HWDATA[15:8];
					s_d.auto_fc        = HWDATA[16];
				end
				`OBC_EVENT_OFS:     s_d.blk_param = HWDATA[7:0];
				default: ;
			endcase
		end
		// a read in a write's data phase sees the word from before that write
		// address phase capture and read data
		s_d.ph_wr   = acc & HWRITE;
		s_d.ph_rd   = acc & ~HWRITE;
		s_d.ph_addr = acc ? HADDR : s_q.ph_addr;
		s_d.rdata   = 32'h0000_0000;
		if (acc && !HWRITE) begin
			user_data = (s_q.fc_mode != OBC_FC_AUTO);
			case (HADDR)
				`OBC_STAT_OFS: s_d.rdata = {20'h00000, s_q.st == OBC_ST_FI, s_q.err,
					s_q.ifr, s_q.iso, s_q.fc_mode, s_q.fc_len[1:0], s_q.hdr, s_q.echo};
				`OBC_PROTO_OFS: s_d.rdata = {8'h00, 8'h00, 8'h00,
					3'h0, s_q.auto_srch, s_q.proto};
				`OBC_FCID_OFS:      s_d.rdata = s_q.fc_id;
				`OBC_FCDATA_LO_OFS: s_d.rdata = user_data ? fc_pad[31:0] : 32'h0;
				`OBC_FCDATA_HI_OFS: s_d.rdata = {15'h0000, s_q.auto_fc, s_q.filler,
					user_data ? fc_pad[39:32] : 8'h00};
				`OBC_EVENT_OFS: s_d.rdata = {22'h000000, s_q.ev_lv, s_q.ev_fatal, s_q.blk_param};
				`OBC_DESC_OFS:  s_d.rdata = {8'h00, 7'h00, s_q.auto_srch, 12'h000, s_q.proto};
				`OBC_IDENT_OFS: s_d.rdata = `OBC_IDENT_WORD;
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		// output flops follow the option state so they change with it
		case (s_d.iso)
			OBC_ISO_4800: s_d.baud = `OBC_BAUD_4800;
			OBC_ISO_9600: s_d.baud = `OBC_BAUD_9600;
			default:      s_d.baud = `OBC_BAUD_10400;
		endcase
		s_d.relaxed = (s_d.iso != OBC_ISO_10400);
		s_d.fi_act  = (s_d.st == OBC_ST_FI);
		s_d.rdy     = 1'b1; // zero wait state slave
		// a latched event blocks the can search only while its parameter bit is set
		s_d.blk = (s_d.ev_fatal & s_d.blk_param[`OBC_BLK_FATAL_BIT])
			| (s_d.ev_lv & s_d.blk_param[`OBC_BLK_LV_BIT]);
	end

	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			s_q           <= '0;
			s_q.echo      <= `OBC_ECHO_RST;
			s_q.hdr       <= `OBC_HDR_RST;
			s_q.auto_srch <= `OBC_AUTO_RST;
			s_q.proto     <= `OBC_PROTO_RST;
			s_q.fc_mode   <= OBC_FC_AUTO;
			s_q.auto_fc   <= 1'b1;
			s_q.filler    <= `OBC_FILLER_RST;
			s_q.iso       <= OBC_ISO_10400;
			s_q.ifr       <= OBC_IFR_HEADER;
			s_q.st        <= OBC_ST_IDLE;
			s_q.baud      <= `OBC_BAUD_10400;
			s_q.rdy       <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	//--------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------
	// every output below except HRESP comes straight from a state flop
	assign HRDATA             = s_q.rdata;
	assign HREADYOUT          = s_q.rdy;
	assign HRESP              = 1'b0; // every response is okay
	assign ECHO_CHAR          = s_q.echo_c;
	assign ECHO_VALID         = s_q.echo_v;
	assign FLOW_CTRL_SEND     = s_q.fc_send;
	assign IFR_SEND           = s_q.ifr_send;
	assign PROTO_CLOSE        = s_q.close;
	assign FAST_INIT_ACTIVE   = s_q.fi_act;
	assign CAN_SEARCH_BLOCKED = s_q.blk;
	assign SHOW_HEADERS       = s_q.hdr;
	assign ISO_BAUD           = s_q.baud;
	assign ISO_RELAXED_INIT   = s_q.relaxed;

endmodule // obc_core

`default_nettype wire

// ===== sim/obc_core_chk.sv
// assertion checker for the option command interpreter
`timescale 1ns/100ps
`default_nettype none

module obc_core_chk #(
	parameter int FI_CYC = 4
) (
	// clock, reset and bus select
	input wire logic        REF_CLK,
	input wire logic        RESET_N,
	input wire logic        HSEL,
	// host side characters
	input wire logic [7:0]  RX_CHAR,
	input wire logic        RX_VALID,
	input wire logic [7:0]  ECHO_CHAR,
	input wire logic        ECHO_VALID,
	// vehicle side
	input wire logic        FIRST_FRAME_RX,
	input wire logic        J1850_MSG_RX,
	input wire logic        FLOW_CTRL_SEND,
	input wire logic        IFR_SEND,
	input wire logic        PROTO_CLOSE,
	input wire logic        FAST_INIT_ACTIVE,
	input wire logic        CAN_SEARCH_BLOCKED,
	input wire logic        SHOW_HEADERS,
	input wire logic [15:0] ISO_BAUD,
	input wire logic        ISO_RELAXED_INIT
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	logic [15:0] fi_q;
	// counts cycles of a running fast init
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N || !FAST_INIT_ACTIVE) begin
			fi_q <= 16'h0000;
		end else begin
			fi_q <= fi_q + 16'h0001;
		end
	end
	AST_ECHO: assert property (ECHO_VALID |-> $past(RX_VALID) && ECHO_CHAR == $past(RX_CHAR))
		else $error("echo without a received char");
	AST_FC: assert property (FLOW_CTRL_SEND |-> $past(FIRST_FRAME_RX))
		else $error("flow control without first frame");
	AST_IFR: assert property (IFR_SEND |-> $past(J1850_MSG_RX))
		else $error("ifr without message");
	AST_BLK: assert property (CAN_SEARCH_BLOCKED && !HSEL && !$past(HSEL) && !$past(HSEL, 2)
		|=> CAN_SEARCH_BLOCKED) else $error("search block dropped without command");
	AST_FI_LEN: assert property ($fell(FAST_INIT_ACTIVE) |-> fi_q == FI_CYC)
		else $error("fast init length wrong");
	AST_BAUD: assert property (ISO_BAUD inside {16'h12C0, 16'h2580, 16'h28A0}
		&& ISO_RELAXED_INIT == (ISO_BAUD != 16'h28A0)) else $error("iso rate pairing wrong");
	AST_RST: assert property (!$past(RESET_N) |-> ISO_BAUD == 16'h28A0 && !SHOW_HEADERS)
		else $error("reset defaults wrong");
	AST_CLOSE: assert property (PROTO_CLOSE |=> !PROTO_CLOSE)
		else $error("close is not a pulse");
	// main scenarios seen
	cover property (FLOW_CTRL_SEND);
	cover property (IFR_SEND);
	cover property ($fell(FAST_INIT_ACTIVE));
endmodule // obc_core_chk

bind obc_core obc_core_chk #(.FI_CYC(FI_CYC)) u_chk (
	.REF_CLK(REF_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .RX_CHAR(RX_CHAR),
	.RX_VALID(RX_VALID), .ECHO_CHAR(ECHO_CHAR), .ECHO_VALID(ECHO_VALID),
	.FIRST_FRAME_RX(FIRST_FRAME_RX), .J1850_MSG_RX(J1850_MSG_RX),
	.FLOW_CTRL_SEND(FLOW_CTRL_SEND), .IFR_SEND(IFR_SEND), .PROTO_CLOSE(PROTO_CLOSE),
	.FAST_INIT_ACTIVE(FAST_INIT_ACTIVE), .CAN_SEARCH_BLOCKED(CAN_SEARCH_BLOCKED),
	.SHOW_HEADERS(SHOW_HEADERS), .ISO_BAUD(ISO_BAUD), .ISO_RELAXED_INIT(ISO_RELAXED_INIT));
`default_nettype wire

// ===== sim/obc_veh_model.sv
// vehicle side model: event and message pulses
`timescale 1ns/100ps
`default_nettype none

module obc_veh_model (
	// clock
	input wire logic   REF_CLK,
	// fatal, low voltage, first frame, j1850 message
	output logic [3:0] EV,
	output logic       K_BIT
);
	initial begin
		EV = 4'h0;
		K_BIT = 1'b0;
	end
	// one cycle pulse; k bit only meaningful with the message, inverted after
	task automatic pulse(input int i, input logic kb);
		@(posedge REF_CLK);
		EV[i] <= 1'b1;
		K_BIT <= kb;
		@(posedge REF_CLK);
		EV <= 4'h0;
		K_BIT <= ~kb;
		#1;
	endtask
endmodule // obc_veh_model
`default_nettype wire

// ===== sim/obd_bridge_option_command_set_tb_top.sv
// testbench for the option command interpreter
`timescale 1ns/100ps
`default_nettype none
`include "obc_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module obd_bridge_option_command_set_tb_top;
	import obc_pkg::*;
	logic        REF_CLK, RESET_N, HSEL, HWRITE, RX_VALID, HREADYOUT, HRESP, ECHO_VALID;
	logic        k_bit, FLOW_CTRL_SEND, IFR_SEND, PROTO_CLOSE, FAST_INIT_ACTIVE;
	logic        CAN_SEARCH_BLOCKED, SHOW_HEADERS, ISO_RELAXED_INIT;
	logic [7:0]  HADDR, RX_CHAR, ECHO_CHAR;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA, HRDATA, rd;
	logic [3:0]  ev;
	logic [15:0] ISO_BAUD;
	int          errors, checked, closes, i;
	logic [7:0]  iso_arg[3] = '{8'h48, 8'h96, 8'h10};
	logic [15:0] iso_bd[3] = '{16'h12C0, 16'h2580, 16'h28A0};
	logic [7:0]  ev_par[3] = '{8'h30, 8'h30, 8'h10};
	logic [7:0]  ifr_arg[4] = '{8'h00, 8'h02, 8'h01, 8'h01};
	logic [3:0]  ifr_kb = 4'h5;
	logic [3:0]  ifr_ex = 4'h6;

	obc_core #(.FI_CYC(4)) DUT (
		.REF_CLK(REF_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_CHAR(RX_CHAR), .RX_VALID(RX_VALID),
		.ECHO_CHAR(ECHO_CHAR), .ECHO_VALID(ECHO_VALID), .FATAL_CAN_ERROR_EVENT(ev[0]),
		.LOW_VOLTAGE_RESET_EVENT(ev[1]), .FIRST_FRAME_RX(ev[2]), .J1850_MSG_RX(ev[3]),
		.J1850_K_BIT(k_bit), .FLOW_CTRL_SEND(FLOW_CTRL_SEND), .IFR_SEND(IFR_SEND),
		.PROTO_CLOSE(PROTO_CLOSE), .FAST_INIT_ACTIVE(FAST_INIT_ACTIVE),
		.CAN_SEARCH_BLOCKED(CAN_SEARCH_BLOCKED), .SHOW_HEADERS(SHOW_HEADERS),
		.ISO_BAUD(ISO_BAUD), .ISO_RELAXED_INIT(ISO_RELAXED_INIT));
	obc_veh_model VEH (.REF_CLK(REF_CLK), .EV(ev), .K_BIT(k_bit));

	// clock and close counter
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) if (PROTO_CLOSE === 1'b1) closes++;

	// verdict and end of run
	task automatic results();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one bus word: address phase then data phase, read data kept in rd
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 50);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 100);
		rd = HRDATA;
		if (n >= 100) begin
			errors++;
			results();
		end
	endtask
	task automatic cmd(input obc_op_t op, input logic [7:0] arg, input logic [2:0] len);
		xfer(1'b1, `OBC_CMD_OFS, {13'h0000, len, arg, 4'h0, op});
		xfer(1'b0, `OBC_STAT_OFS, 32'h0000_0000);
	endtask
	task automatic rx(input logic [7:0] c);
		@(posedge REF_CLK);
		RX_CHAR <= c;
		RX_VALID <= 1'b1;
		@(posedge REF_CLK);
		RX_VALID <= 1'b0;
		#1;
	endtask
	task automatic wait_fi(input logic v);
		int n;
		n = 0;
		while (FAST_INIT_ACTIVE !== v && n < 40) begin
			@(posedge REF_CLK);
			#1;
			n++;
		end
		`CHK("fast_init", v, FAST_INIT_ACTIVE)
		if (n >= 40) results();
	endtask

	// main sequence
	initial begin
		{RESET_N, HSEL, HWRITE, RX_VALID, HTRANS, HADDR, RX_CHAR, HWDATA} = '0;
		HSIZE = 3'h2;
		{errors, checked, closes} = '0;
		repeat (5) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		#1;
		`CHK("iso_baud", `OBC_BAUD_10400, ISO_BAUD)
		`CHK("show_hdr", 1'b0, SHOW_HEADERS)
		xfer(1'b0, `OBC_STAT_OFS, 32'h0);
		`CHK("stat", 32'h0000_0101, rd)
		xfer(1'b0, `OBC_IDENT_OFS, 32'h0);
		`CHK("ident", `OBC_IDENT_WORD, rd)
		xfer(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		xfer(1'b0, `OBC_PROTO_OFS, 32'h0);
		`CHK("proto", 32'h0000_0010, rd)
		xfer(1'b0, `OBC_DESC_OFS, 32'h0);
		`CHK("desc", 32'h0001_0000, rd)
		$display("test reset done");
		rx(8'hA5);
		`CHK("echo", 9'h1A5, {ECHO_VALID, ECHO_CHAR})
		cmd(OBC_OP_ECHO_OFF, 8'h00, 3'h0);
		rx(8'h5A);
		`CHK("no_echo", 1'b0, ECHO_VALID)
		cmd(OBC_OP_HDR_ON, 8'h00, 3'h0);
		`CHK("hdr_on", 2'b11, {SHOW_HEADERS, rd[1]})
		$display("test echo header done");
		for (i = 0; i < 3; i++) begin
			cmd(OBC_OP_ISO_RATE, iso_arg[i], 3'h0);
			`CHK("iso", {iso_bd[i], i < 2}, {ISO_BAUD, ISO_RELAXED_INIT})
		end
		$display("test iso done");
		cmd(OBC_OP_FC_MODE, 8'h02, 3'h0);
		`CHK("fc_rej", 3'b100, {rd[10], rd[5:4]})
		xfer(1'b1, `OBC_FCID_OFS, 32'hFFFF_FFFF);
		cmd(OBC_OP_FC_ID11, 8'h00, 3'h0);
		xfer(1'b0, `OBC_FCID_OFS, 32'h0);
		`CHK("id11", `OBC_ID11_MASK, rd)
		xfer(1'b1, `OBC_FCID_OFS, 32'hFFFF_FFFF);
		cmd(OBC_OP_FC_ID29, 8'h00, 3'h0);
		xfer(1'b0, `OBC_FCID_OFS, 32'h0);
		`CHK("id29", `OBC_ID29_MASK, rd)
		xfer(1'b1, `OBC_FCDATA_LO_OFS, 32'h1122_3344);
		cmd(OBC_OP_FC_DATA, 8'h00, 3'h5);
		cmd(OBC_OP_FC_MODE, 8'h02, 3'h0);
		`CHK("fc_mode2", 2'h2, rd[5:4])
		cmd(OBC_OP_FC_MODE, 8'h01, 3'h0);
		xfer(1'b0, `OBC_FCDATA_LO_OFS, 32'h0);
		`CHK("fc_data1", 32'h1122_3344, rd)
		cmd(OBC_OP_FC_MODE, 8'h00, 3'h0);
		xfer(1'b0, `OBC_FCDATA_LO_OFS, 32'h0);
		`CHK("fc_data0", 32'h0, rd)
		xfer(1'b1, `OBC_FCDATA_HI_OFS, 32'h0001_AA55);
		cmd(OBC_OP_FC_DATA, 8'h00, 3'h6);
		`CHK("fc_len_rej", 1'b1, rd[10])
		cmd(OBC_OP_FC_DATA, 8'h00, 3'h2);
		cmd(OBC_OP_FC_MODE, 8'h02, 3'h0);
		xfer(1'b0, `OBC_FCDATA_LO_OFS, 32'h0);
		`CHK("fc_pad_lo", 32'hAAAA_3344, rd)
		xfer(1'b0, `OBC_FCDATA_HI_OFS, 32'h0);
		`CHK("fc_pad_hi", 32'h0001_AAAA, rd)
		cmd(OBC_OP_FC_MODE, 8'h00, 3'h0);
		VEH.pulse(2, 1'b0);
		`CHK("fc_send", 1'b1, FLOW_CTRL_SEND)
		$display("test flow control done");
		for (i = 0; i < 4; i++) begin
			cmd(OBC_OP_IFR, ifr_arg[i], 3'h0);
			VEH.pulse(3, ifr_kb[i]);
			`CHK("ifr", ifr_ex[i], IFR_SEND)
		end
		cmd(OBC_OP_IFR, 8'h03, 3'h0);
		`CHK("ifr_rej", 3'h5, {rd[10], rd[9:8]})
		$display("test ifr done");
		for (i = 0; i < 3; i++) begin
			xfer(1'b1, `OBC_EVENT_OFS, {24'h0, ev_par[i]});
			VEH.pulse(i % 2, 1'b0);
			@(posedge REF_CLK);
			#1;
			`CHK("blocked", i < 2, CAN_SEARCH_BLOCKED)
			cmd(OBC_OP_FORGET, 8'h00, 3'h0);
			`CHK("forgot", 1'b0, CAN_SEARCH_BLOCKED)
		end
		$display("test events done");
		cmd(OBC_OP_FAST_INIT, 8'h00, 3'h0);
		`CHK("fi_rej", 2'b10, {rd[10], FAST_INIT_ACTIVE})
		cmd(OBC_OP_SET_PROTO, 8'h05, 3'h0);
		xfer(1'b0, `OBC_PROTO_OFS, 32'h0);
		`CHK("proto5", 32'h5, rd)
		cmd(OBC_OP_SET_PROTO, 8'h05, 3'h0);
		`CHK("closes", 1, closes)
		cmd(OBC_OP_FAST_INIT, 8'h00, 3'h0);
		wait_fi(1'b1);
		wait_fi(1'b0);
		$display("test fast init done");
		cmd(OBC_OP_DEFAULTS, 8'h00, 3'h0);
		`CHK("defaults", 1'b0, SHOW_HEADERS)
		$display("test defaults done");
		results();
	end
endmodule // obd_bridge_option_command_set_tb_top
`default_nettype wire
